// *** inc/optmod_pkg.sv ***
package optmod_pkg;
  // clock of both ends, in ns
  localparam int unsigned CLK_NS          = 50;
  // two-wire addresses (8-bit form, write)
  localparam logic [7:0]  ADDR_ID         = 8'ha0;
  localparam logic [7:0]  ADDR_DIAG       = 8'ha2;
  localparam logic [7:0]  CTRL_OFFSET     = 8'h6e;
  // control/status byte fields
  localparam int unsigned BIT_SOFT_OFF    = 6;
  localparam int unsigned BIT_FAULT       = 2;
  localparam int unsigned BIT_LOSS        = 1;
  localparam int unsigned BIT_READY       = 0;
  localparam logic [7:0]  CTRL_RESET      = 8'h00;
  localparam logic [7:0]  CTRL_WR_MASK    = 8'h40;
  // device timing, in ns, scl rate in kHz (limits as printed)
  localparam int unsigned T_OFF_NS        = 10000;
  localparam int unsigned T_RESET_NS      = 10000;
  localparam int unsigned T_FAULT_NS      = 100000;
  localparam int unsigned T_LOS_NS        = 100000;
  localparam int unsigned T_INIT_NS       = 300000000;
  localparam int unsigned T_DATA_NS       = 1000000000;
  localparam int unsigned T_WRITE4_NS     = 40000000;
  localparam int unsigned T_WRITE8_NS     = 80000000;
  localparam int unsigned T_DIS_GAP_NS    = 10000000;
  localparam int unsigned T_BUF_NS        = 20000;
  localparam int unsigned F_SCL_MAX_KHZ   = 400;
  // derived cycle counts (least rounds up)
  localparam int unsigned RESET_CYC  = (T_RESET_NS + CLK_NS - 1) / CLK_NS;
  localparam int unsigned BUF_CYC    = (T_BUF_NS + CLK_NS - 1) / CLK_NS;
  localparam int unsigned DIS_GAP_CYC = (T_DIS_GAP_NS + CLK_NS - 1) / CLK_NS;
  localparam int unsigned INIT_CYC   = T_INIT_NS / CLK_NS;
  localparam int unsigned DATA_CYC   = T_DATA_NS / CLK_NS;
  localparam int unsigned WRITE4_CYC = (T_WRITE4_NS + CLK_NS - 1) / CLK_NS;
  localparam int unsigned WRITE8_CYC = (T_WRITE8_NS + CLK_NS - 1) / CLK_NS;
  // half period of scl: 1/(2*400k)=1250 ns, rounded up
  localparam int unsigned SCL_HALF_CYC =
    (1000000 / (2 * F_SCL_MAX_KHZ) + CLK_NS - 1) / CLK_NS;
  // host command register map
  localparam logic [3:0]  REG_CMD         = 4'h0;
  localparam logic [3:0]  REG_WDATA       = 4'h1;
  localparam logic [3:0]  REG_STATUS      = 4'h2;
  localparam logic [3:0]  REG_RDATA       = 4'h3;
  localparam logic [3:0]  REG_PINS        = 4'h4;
  localparam int unsigned CMD_READ        = 0;
  localparam int unsigned CMD_DIS_PIN     = 1;
endpackage

// *** inc/optmod_if.sv ***
`timescale 1ns/10ps
interface optmod_if;
  logic tx_disable;
  logic tx_fault;
  logic rx_loss;
  logic scl;
  logic sda_dev_o;
  logic sda_dev_oe;
  logic sda_host_o;
  logic sda_host_oe;
  logic sda;
  // open drain: low wins, pulled up otherwise
  assign sda = ~((sda_dev_oe & ~sda_dev_o) | (sda_host_oe & ~sda_host_o));
  modport device (input tx_disable, input scl, input sda,
                  output tx_fault, output rx_loss,
                  output sda_dev_o, output sda_dev_oe);
  modport host (output tx_disable, output scl, input sda,
                input tx_fault, input rx_loss,
                output sda_host_o, output sda_host_oe);
endinterface

// *** hw/sync2.sv ***
`timescale 1ns/10ps
module sync2 #(
  parameter int W = 1
) (
  input  wire logic         clock_i,
  input  wire logic         rst_n_i,
  input  wire logic [W-1:0] d_i,
  output logic      [W-1:0] q_o
);
  logic [W-1:0] meta;
  // two-stage synchroniser; meta feeds only q_o
  always_ff @(posedge clock_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      meta <= '0;
      q_o  <= '0;
    end else begin
      meta <= d_i;
      q_o  <= meta;
    end
  end
endmodule

// *** hw/optmod_device.sv ***
`timescale 1ns/10ps
module optmod_device #(
  parameter int unsigned INIT_CYC = optmod_pkg::INIT_CYC,
  parameter int unsigned DATA_CYC = optmod_pkg::DATA_CYC
) (
  // link to host
  optmod_if.device  link,
  // optical front end
  input  wire logic clock_i,
  input  wire logic rst_n_i,
  input  wire logic laser_fault_i,
  input  wire logic signal_ok_i,
  output logic      laser_on_o,
  // state visible to user
  output logic [7:0] ctrl_o
);
  typedef enum logic [2:0] {
    ST_IDLE, ST_ADDR, ST_ACK, ST_DATA, ST_DACK, ST_RD, ST_RACK
  } bus_t;
  typedef struct packed {
    bus_t        bus;
    logic [3:0]  bits;
    logic [7:0]  sh;
    logic        dir_rd;
    logic        diag;
    logic        have_off;
    logic [7:0]  ptr;
    logic        soft_off;
    logic        fault;
    logic        loss;
    logic        ready;
    logic        inited;
    logic        booted;
    logic [31:0] init_cnt;
    logic [31:0] data_cnt;
    logic [15:0] dis_cnt;
    logic        dis_d;
    logic        scl_d;
    logic        sda_d;
    logic        sda_oe;
    logic        laser_on;
    logic        fault_o;
    logic        loss_o;
  } dev_t;
  dev_t s, n;
  logic [3:0] raw, syn;
  logic dis, scl, sda, flt, sok;
  assign raw = {link.tx_disable, link.scl, link.sda, laser_fault_i};
  sync2 #(.W(5)) u_sync (
    .clock_i (clock_i),
    .rst_n_i (rst_n_i),
    .d_i     ({raw, signal_ok_i}),
    .q_o     ({syn, sok})
  );
  assign {dis, scl, sda, flt} = syn;
  // next state of the whole device
  always_comb begin
    n = s;
    n.scl_d = scl;
    n.sda_d = sda;
    n.dis_d = dis;
    // init timer restarts on power-on and disable falling edge
    // init timer
    if (s.dis_d && !dis) begin
      n.init_cnt = '0;
      n.inited = 1'b0;
    end else if (s.init_cnt < INIT_CYC[31:0]) begin
      n.init_cnt = s.init_cnt + 32'h1;
    end else begin
      n.inited = 1'b1;
      // laser gate only waits for the first init after power-on
      n.booted = 1'b1;
    end
    if (s.data_cnt < DATA_CYC[31:0]) n.data_cnt = s.data_cnt + 32'h1;
    else n.ready = 1'b1;
    if (dis) begin
      if (s.dis_cnt < optmod_pkg::RESET_CYC[15:0])
        n.dis_cnt = s.dis_cnt + 16'h1;
    end else begin
      n.dis_cnt = '0;
    end
    if (flt && s.inited) n.fault = 1'b1;
    else if (s.dis_cnt >= optmod_pkg::RESET_CYC[15:0]) n.fault = 1'b0;
    n.loss = ~sok;
    // soft clear relights
    // re-init after a release must not hold the laser off past 2 ms
    n.laser_on = ~dis & ~s.soft_off & ~s.fault & s.booted;
    n.fault_o = s.fault;
    n.loss_o = s.loss;
    // two-wire slave, sampled on scl edges
    if (s.scl_d && scl && s.sda_d && !sda) begin
      n.bus = ST_ADDR;
      n.bits = '0;
      n.sda_oe = 1'b0;
      n.have_off = 1'b0;
    end else if (s.scl_d && scl && !s.sda_d && sda) begin
      n.bus = ST_IDLE;
      n.sda_oe = 1'b0;
    end else if (!s.scl_d && scl) begin
      // rising scl: shift in
      if (s.bus == ST_ADDR || s.bus == ST_DATA) begin
        n.sh = {s.sh[6:0], sda};
        n.bits = s.bits + 4'h1;
      end else if (s.bus == ST_RACK && sda) begin
        n.bus = ST_IDLE;
      end
    end else if (s.scl_d && !scl) begin
      // falling scl: drive ack or data
      case (s.bus)
        ST_ADDR: begin
          if (s.bits == 4'h8) begin
            n.dir_rd = s.sh[0];
            n.diag = ({s.sh[7:1], 1'b0} == optmod_pkg::ADDR_DIAG);
            if (s.inited && ({s.sh[7:1], 1'b0} == optmod_pkg::ADDR_DIAG
                || {s.sh[7:1], 1'b0} == optmod_pkg::ADDR_ID)) begin
              n.bus = ST_ACK;
              n.sda_oe = 1'b1;
            end else begin
              n.bus = ST_IDLE;
            end
          end
        end
        ST_ACK, ST_DACK, ST_RACK: begin
          n.sda_oe = 1'b0;
          n.bits = '0;
          if (s.dir_rd) begin
            n.bus = ST_RD;
            n.sh = (s.diag && s.ptr == optmod_pkg::CTRL_OFFSET) ?
                   {1'b0, s.soft_off, 3'h0, s.fault, s.loss, s.ready} :
                   8'h00;
            n.sda_oe = ~n.sh[7];
            if (s.bus != ST_ACK) n.ptr = s.ptr + 8'h1;
          end else begin
            n.bus = ST_DATA;
          end
        end
        ST_DATA: begin
          if (s.bits == 4'h8) begin
            n.bus = ST_DACK;
            n.sda_oe = 1'b1;
            if (!s.have_off) begin
              n.ptr = s.sh;
              n.have_off = 1'b1;
            end else begin
              // write to soft-off takes effect at once
              if (s.diag && s.ptr == optmod_pkg::CTRL_OFFSET)
                n.soft_off = s.sh[optmod_pkg::BIT_SOFT_OFF];
              n.ptr = s.ptr + 8'h1;
            end
          end
        end
        // read byte goes out msb first, then the master acks
        ST_RD: begin
          if (s.bits == 4'h7) begin
            n.bus = ST_RACK;
            n.sda_oe = 1'b0;
          end else begin
            n.sh = {s.sh[6:0], 1'b0};
            n.sda_oe = ~s.sh[6];
            n.bits = s.bits + 4'h1;
          end
        end
        default: n.bus = ST_IDLE;
      endcase
    end
  end
  // state register
  always_ff @(posedge clock_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      s <= '0;
    end else begin
      s <= n;
    end
  end
  // pins come straight from state flops
  assign link.tx_fault = s.fault_o;
  assign link.rx_loss = s.loss_o;
  assign link.sda_dev_o = 1'b0;
  assign link.sda_dev_oe = s.sda_oe;
  assign laser_on_o = s.laser_on;
  assign ctrl_o = {1'b0, s.soft_off, 3'h0, s.fault, s.loss, s.ready};
endmodule

// *** hw/optmod_host.sv ***
`timescale 1ns/10ps
module optmod_host #(
  parameter int unsigned WRITE4_CYC = optmod_pkg::WRITE4_CYC
) (
  // link to module
  optmod_if.host    link,
  input  wire logic clock_i,
  input  wire logic rst_n_i,
  // software port
  input  wire logic [3:0] addr_i,
  input  wire logic [7:0] wdata_i,
  input  wire logic       wr_i,
  input  wire logic       rd_i,
  output logic      [7:0] rdata_o
);
  typedef enum logic [2:0] {
    H_IDLE, H_START, H_BIT, H_STOP, H_WAIT
  } hst_t;
  typedef struct packed {
    hst_t        st;
    logic [5:0]  bitn;
    logic [26:0] seq;
    logic        is_rd;
    logic        rd_next;
    logic [7:0]  rx;
    logic [31:0] dis_wait;
    logic [15:0] div;
    logic [31:0] wait_cnt;
    logic        dis_pin;
    logic        scl;
    logic        sda_oe;
    logic [7:0]  wdata;
    logic [7:0]  rdata;
  } host_t;
  host_t s, n;
  logic [2:0] syn;
  sync2 #(.W(3)) u_sync (
    .clock_i (clock_i),
    .rst_n_i (rst_n_i),
    .d_i     ({link.sda, link.tx_fault, link.rx_loss}),
    .q_o     (syn)
  );
  // host sequencer and register file
  always_comb begin
    n = s;
    if (wr_i && addr_i == optmod_pkg::REG_WDATA) n.wdata = wdata_i;
    if (s.dis_wait != 32'h0) n.dis_wait = s.dis_wait - 32'h1;
    if (wr_i && addr_i == optmod_pkg::REG_PINS) begin
      if (!wdata_i[0]) begin
        n.dis_pin = 1'b0;
      end else if (!s.dis_pin && s.dis_wait == 32'h0) begin
        n.dis_pin = 1'b1;
        n.dis_wait = 32'(optmod_pkg::DIS_GAP_CYC);
      end
    end
    if (rd_i) begin
      case (addr_i)
        optmod_pkg::REG_STATUS:
          n.rdata = {5'h0, syn[1], syn[0], s.st != H_IDLE};
        optmod_pkg::REG_RDATA: n.rdata = s.rx;
        optmod_pkg::REG_PINS:  n.rdata = {7'h0, s.dis_pin};
        default:               n.rdata = 8'h00;
      endcase
    end
    n.div = s.div + 16'h1;
    case (s.st)
      H_IDLE: begin
        n.div = '0;
        if (wr_i && addr_i == optmod_pkg::REG_CMD) begin
          // a read first sets the pointer in a short write of its own,
          // since the pointer has moved past the byte after any write
          n.is_rd = 1'b0;
          n.rd_next = wdata_i[optmod_pkg::CMD_READ];
          // addr, ack, offset, ack, data, ack
          n.seq = {optmod_pkg::ADDR_DIAG, 1'b1, optmod_pkg::CTRL_OFFSET,
                   1'b1, s.wdata, 1'b1};
          n.bitn = '0;
          n.st = H_START;
        end
      end
      H_START: begin
        n.sda_oe = 1'b1;
        if (s.div == optmod_pkg::SCL_HALF_CYC[15:0]) begin
          n.div = '0;
          n.scl = 1'b0;
          n.st = H_BIT;
        end
      end
      H_BIT: begin
        if (s.div == optmod_pkg::SCL_HALF_CYC[15:0]) begin
          n.div = '0;
          n.scl = ~s.scl;
          if (s.scl) begin
            n.bitn = s.bitn + 6'h1;
            n.seq = {s.seq[25:0], 1'b1};
            n.sda_oe = ~s.seq[25];
            if (s.bitn == ((s.is_rd || s.rd_next) ? 6'd17 : 6'd26)) begin
              n.st = H_STOP;
              n.sda_oe = 1'b1;
            end
          end else begin
            if (s.is_rd && s.bitn >= 6'd9 && s.bitn < 6'd17)
              n.rx = {s.rx[6:0], syn[2]};
          end
        end else if (s.bitn == 6'h0 && !s.scl && s.div == 16'h1) begin
          n.sda_oe = ~s.seq[26];
        end
      end
      H_STOP: begin
        if (s.div == optmod_pkg::SCL_HALF_CYC[15:0]) begin
          n.div = '0;
          if (!s.scl) begin
            n.scl = 1'b1;
          end else begin
            n.sda_oe = 1'b0;
            n.wait_cnt = '0;
            n.st = H_WAIT;
          end
        end
      end
      H_WAIT: begin
        // write-cycle wait, bus-free time
        // bus-free time also guards writes, whose wait may be set shorter
        n.wait_cnt = s.wait_cnt + 32'h1;
        if (s.wait_cnt >= optmod_pkg::BUF_CYC &&
            (s.is_rd || s.rd_next || s.wait_cnt >= WRITE4_CYC)) begin
          n.st = H_IDLE;
          if (s.rd_next) begin
            // pointer set: fetch the byte under a fresh start
            n.rd_next = 1'b0;
            n.is_rd = 1'b1;
            n.seq = {optmod_pkg::ADDR_DIAG | 8'h01, 1'b1, 8'hff, 1'b1,
                     9'h1ff};
            n.bitn = '0;
            n.div = '0;
            n.st = H_START;
          end
        end
      end
      default: n.st = H_IDLE;
    endcase
  end
  // state register; scl idles high
  always_ff @(posedge clock_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      s <= '0;
      s.scl <= 1'b1;
    end else begin
      s <= n;
    end
  end
  assign link.scl = s.scl;
  assign link.tx_disable = s.dis_pin;
  assign link.sda_host_o = 1'b0;
  assign link.sda_host_oe = s.sda_oe;
  assign rdata_o = s.rdata;
endmodule

// *** bench/optmod_chk.sv ***
`timescale 1ns/10ps
module optmod_chk #(
  parameter int unsigned INIT_CYC = 200
) (
  // clock and reset
  input  wire logic clock_i,
  input  wire logic rst_n_i,
  // link signals
  input  wire logic tx_disable,
  input  wire logic tx_fault,
  input  wire logic rx_loss,
  input  wire logic scl,
  input  wire logic sda,
  // optical front end
  input  wire logic laser_fault_i,
  input  wire logic signal_ok_i,
  input  wire logic laser_on_o
);
  localparam int LIM = 2000; // 100 us of clock
  logic [15:0] up, dis, mis, fcnt, hi, bf;
  logic        scl_q;
  logic        sda_q;
  logic [31:0] dg;
  wire         init = (up >= 16'(INIT_CYC));
  wire         stop = scl && scl_q && sda && !sda_q;
  // spans of stuck states; up, hi, bf and dg saturate so long idles never wrap to zero
  always_ff @(posedge clock_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      up <= '0;
      dis <= '0;
      mis <= '0;
      fcnt <= '0;
      hi <= '0;
      bf <= 16'hffff;
      dg <= 32'hffffffff;
      scl_q <= 1'b1;
      sda_q <= 1'b1;
    end else begin
      up <= up + {15'h0, up != 16'hffff};
      dis <= tx_disable ? dis + 16'h1 : '0;
      mis <= (init && rx_loss == signal_ok_i) ? mis + 16'h1 : '0;
      fcnt <= (init && laser_fault_i && !tx_fault && !tx_disable) ?
              fcnt + 16'h1 : '0;
      hi <= (scl != scl_q) ? '0 : hi + {15'h0, hi != 16'hffff};
      dg <= (tx_disable && dis == '0) ? '0 : dg + {31'h0, dg != 32'hffffffff};
      bf <= stop ? '0 : bf + {15'h0, bf != 16'hffff};
      scl_q <= scl;
      sda_q <= sda;
    end
  end
  default clocking cb @(posedge clock_i); endclocking
  default disable iff (!rst_n_i);
  sequence s_start;
    scl_q && scl && sda_q && !sda;
  endsequence
  chk_pin_off: assert property (
    $rose(tx_disable) |-> ##[1:200] !laser_on_o)
    else $error("laser stays lit after pin disable");
  chk_off_hold: assert property (
    tx_disable [*8] |-> !laser_on_o)
    else $error("laser lit while disabled");
  chk_fault_dark: assert property (
    tx_fault [*8] |-> !laser_on_o)
    else $error("laser lit during fault");
  chk_fault_latch: assert property (
    tx_fault && !tx_disable |=> tx_fault)
    else $error("fault dropped without disable");
  chk_fault_clear: assert property (
    dis == 16'd215 && !laser_fault_i |-> !tx_fault)
    else $error("fault not cleared by held disable");
  chk_fault_set: assert property (fcnt <= LIM)
    else $error("fault pin late");
  chk_loss_pin: assert property (mis <= LIM)
    else $error("loss pin disagrees with light too long");
  chk_scl_rate: assert property (
    scl != scl_q |-> hi >= 16'(optmod_pkg::SCL_HALF_CYC - 1))
    else $error("scl half period too short");
  chk_bus_free: assert property (
    s_start |-> bf >= 16'(optmod_pkg::BUF_CYC))
    else $error("start too soon after stop");
  chk_early_start: assert property (s_start |-> init)
    else $error("bus used before start-up ends");
  chk_dis_gap: assert property (
    tx_disable && dis == 16'h0 |-> dg >= 32'(optmod_pkg::DIS_GAP_CYC))
    else $error("disable raised again too soon");
endmodule

// *** bench/optical_module_control_status_tb.sv ***
`timescale 1ns/10ps
module optical_module_control_status_tb;
  localparam int unsigned INIT_CYC = 200;
  localparam int unsigned DATA_CYC = 400;
  // clock, reset and software port
  logic       clock_i;
  logic       rst_n_i;
  logic [3:0] addr;
  logic [7:0] wdata;
  logic       wr;
  logic       rd;
  logic [7:0] rdata;
  // optical front end
  logic       laser_fault;
  logic       signal_ok;
  logic       laser_on;
  logic [7:0] ctrl;
  logic [7:0] v;
  int         n_errors;
  int         n_checks;
  int         cyc;
  optmod_if link ();
  optmod_device #(.INIT_CYC(INIT_CYC), .DATA_CYC(DATA_CYC)) u_optmod_device (
    .link          (link.device),
    .clock_i       (clock_i),
    .rst_n_i       (rst_n_i),
    .laser_fault_i (laser_fault),
    .signal_ok_i   (signal_ok),
    .laser_on_o    (laser_on),
    .ctrl_o        (ctrl)
  );
  optmod_host #(.WRITE4_CYC(100)) u_optmod_host (
    .link    (link.host),
    .clock_i (clock_i),
    .rst_n_i (rst_n_i),
    .addr_i  (addr),
    .wdata_i (wdata),
    .wr_i    (wr),
    .rd_i    (rd),
    .rdata_o (rdata)
  );
  optmod_chk #(.INIT_CYC(INIT_CYC)) u_chk (
    .clock_i       (clock_i),
    .rst_n_i       (rst_n_i),
    .tx_disable    (link.tx_disable),
    .tx_fault      (link.tx_fault),
    .rx_loss       (link.rx_loss),
    .scl           (link.scl),
    .sda           (link.sda),
    .laser_fault_i (laser_fault),
    .signal_ok_i   (signal_ok),
    .laser_on_o    (laser_on)
  );
  task automatic wrap_up();
    $display("checks %0d errors %0d", n_checks, n_errors);
    if (n_errors == 0 && n_checks > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask
  task automatic check(input logic [7:0] got, input logic [7:0] exp);
    n_checks++;
    if (got !== exp) begin
      n_errors++;
      $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic dly(input int n);
    repeat (n) @(posedge clock_i);
    #1;
  endtask
  // one-cycle strobes, launched right after an edge
  task automatic wr_reg(input logic [3:0] a, input logic [7:0] d);
    @(posedge clock_i);
    addr <= a;
    wdata <= d;
    wr <= 1'b1;
    @(posedge clock_i);
    wr <= 1'b0;
  endtask
  task automatic rd_reg(input logic [3:0] a);
    @(posedge clock_i);
    addr <= a;
    rd <= 1'b1;
    @(posedge clock_i);
    rd <= 1'b0;
    #1 v = rdata;
  endtask
  // poll busy under a bound so a stuck transfer cannot hang the run
  task automatic wait_idle();
    int i;
    for (i = 0; i < 3000; i++) begin
      rd_reg(optmod_pkg::REG_STATUS);
      if (v[0] === 1'b0) break;
    end
    if (i == 3000) n_errors++;
  endtask
  task automatic put110(input logic [7:0] d);
    wr_reg(optmod_pkg::REG_WDATA, d);
    wr_reg(optmod_pkg::REG_CMD, 8'h00);
    wait_idle();
  endtask
  task automatic get110(input logic [7:0] exp);
    wr_reg(optmod_pkg::REG_CMD, 8'h01);
    wait_idle();
    rd_reg(optmod_pkg::REG_RDATA);
    check(v, exp);
  endtask
  task automatic stat(input logic [7:0] exp);
    rd_reg(optmod_pkg::REG_STATUS);
    check(v, exp);
  endtask
  initial begin
    clock_i = 1'b0;
    forever #25 clock_i = ~clock_i;
  end
  // hang guard, about twice the expected run
  always @(posedge clock_i) begin
    cyc <= cyc + 1;
    if (cyc == 60000) begin
      n_errors++;
      wrap_up();
    end
  end
  initial begin
    {addr, wdata, wr, rd, laser_fault} = '0;
    {signal_ok, n_errors, n_checks, cyc} = '0;
    signal_ok = 1'b1;
    rst_n_i = 1'b0;
    repeat (2) @(posedge clock_i);
    rst_n_i <= 1'b1;
    dly(DATA_CYC + 50);
    check({7'h00, laser_on}, 8'h01);
    get110(8'h01);
    stat(8'h00);
    // only the soft-off bit takes a write
    put110(8'hff);
    check(ctrl, 8'h41);
    dly(200);
    check({7'h00, laser_on}, 8'h00);
    get110(8'h41);
    put110(8'h00);
    dly(200);
    check({7'h00, laser_on}, 8'h01);
    // light lost then back
    signal_ok <= 1'b0;
    dly(2000);
    check({7'h00, link.rx_loss}, 8'h01);
    get110(8'h03);
    signal_ok <= 1'b1;
    dly(2000);
    check({7'h00, link.rx_loss}, 8'h00);
    get110(8'h01);
    // fault latches after its cause goes away
    laser_fault <= 1'b1;
    dly(2000);
    check({7'h00, link.tx_fault}, 8'h01);
    laser_fault <= 1'b0;
    dly(50);
    get110(8'h05);
    stat(8'h04);
    check({7'h00, laser_on}, 8'h00);
    // one disable pulse, held past the reset time
    wr_reg(optmod_pkg::REG_PINS, 8'h01);
    dly(optmod_pkg::RESET_CYC + 20);
    check({7'h00, laser_on}, 8'h00);
    wr_reg(optmod_pkg::REG_PINS, 8'h00);
    dly(20);
    check({7'h00, laser_on}, 8'h01);
    dly(INIT_CYC + 30);
    check({7'h00, link.tx_fault}, 8'h00);
    get110(8'h01);
    // a second disable this soon is refused
    wr_reg(optmod_pkg::REG_PINS, 8'h01);
    rd_reg(optmod_pkg::REG_PINS);
    check(v, 8'h00);
    wrap_up();
  end
endmodule
